/* hw/backup_store.sv */
/*
 * Small store with one write port and one read port standing in for the internal flash image.
 * Read data come out of a register one cycle after the address.
 */
`timescale 1ns/1ps
`default_nettype none
module backup_store
	import lane_flag_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Write side.
	input wire logic wr_en,
	input wire logic [MEM_AW-1:0] wr_addr,
	input wire logic [LANE_W-1:0] wr_data,
	// Read side.
	input wire logic [MEM_AW-1:0] rd_addr,
	output logic [LANE_W-1:0] rd_data
);
	logic [LANE_W-1:0] mem [MEM_DEPTH];

	// Write port; no reset so it maps onto plain storage.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read.
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

/* hw/lane_flag_pins.sv */
/*
 * Data-lane side logic and flag pins of a nonvolatile registered memory
 * module lane: write mask / bus inversion capture on both strobe edges,
 * read inversion, termination strobe select, error alert, thermal event
 * and forced backup copy into a backing store.
 * Assumes strobes, the lane, alert and memory reset pins and the backup trigger are asynchronous to CLK
 * and slow against it (strobe period 160 ns); every one is synchronised.
 */
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module lane_flag_pins
	import lane_flag_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET_N,
	// Memory reset pin, blocked while armed.
	input wire logic MEM_RESET_N,
	output logic MEM_RESET_N_EFF,
	// Register port.
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	// Data strobe pair and lane.
	input wire logic LOWER_BYTE_STROBE,
	input wire logic LOWER_BYTE_STROBE_C,
	input wire logic [LANE_W-1:0] DQ_IN,
	input wire logic WRITE_MASK_N,
	input wire logic WRITE_EN,
	output logic [LANE_W-1:0] STORE_DATA,
	output logic STORE_VALID,
	// Read path.
	input wire logic [LANE_W-1:0] READ_DATA,
	input wire logic READ_EN,
	output logic [LANE_W-1:0] DQ_OUT,
	output logic DQ_OE,
	output logic BUS_INVERT_N_OUT,
	output logic STROBE_OUT,
	// Termination strobe pair.
	output logic TERM_STROBE_TRUE_TERM,
	output logic TERM_STROBE_COMP_TERM,
	// Command parity and CRC status.
	input wire logic CMD_VALID,
	input wire logic [31:0] CMD_BITS,
	input wire logic CMD_PARITY,
	input wire logic CRC_ERROR,
	input wire logic RECOVERY_DONE,
	// Alert pin, three signals.
	input wire logic ALERT_N_IN,
	output logic ALERT_N_OUT,
	output logic ALERT_N_OE,
	// Temperature and event.
	input wire logic [7:0] TEMPERATURE,
	output logic EVENT_N,
	// Backup trigger (open-drain, active low).
	input wire logic BACKUP_TRIGGER_N,
	output logic MUX_TO_FLASH,
	output logic BACKUP_DONE
);

	////////////////////////////////////////////////////////////////////////
	// Shared helpers.

	// Even parity over the command bits plus the parity pin.
	function automatic logic parity_bad(input logic [31:0] bits, input logic par);
		parity_bad = (^bits) ^ par;
	endfunction

	// Conditional byte inversion, low control means invert.
	function automatic logic [LANE_W-1:0] apply_inv(input logic [LANE_W-1:0] d,
			input logic inv_n, input logic en);
		apply_inv = (en && !inv_n) ? ~d : d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers.

	logic [DATA_W-1:0] mode_one_r;
	logic [DATA_W-1:0] mode_five_r;
	logic [DATA_W-1:0] config_r;
	logic [MEM_AW-1:0] mem_addr_r;
	logic [1:0] part_width;
	logic mask_allowed, winv_on, rinv_on, term_on;

	assign part_width = config_r[CFG_WIDTH_LO +: 2];
	// Mask only on x8/x16 and only when chosen by mode five.
	assign mask_allowed = mode_five_r[MR5_MASK_EN_BIT] && (part_width != WIDTH_X4) && !term_on;
	assign winv_on = mode_five_r[MR5_WINV_EN_BIT] && !mask_allowed;
	assign rinv_on = mode_five_r[MR5_RINV_EN_BIT];
	// Termination strobe only honoured on x8 parts.
	assign term_on = mode_one_r[MR1_TERM_STROBE_BIT] && (part_width == WIDTH_X8);

	// Register writes.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			mode_one_r <= MODE_ONE_RST;
			mode_five_r <= MODE_FIVE_RST;
			config_r <= CONFIG_RST;
			mem_addr_r <= '0;
		end else if (REG_WR) begin
			case (REG_ADDR)
				OFF_MODE_ONE: mode_one_r <= REG_WDATA;
				OFF_MODE_FIVE: mode_five_r <= REG_WDATA;
				OFF_CONFIG: config_r <= REG_WDATA;
				OFF_MEM_ADDR: mem_addr_r <= REG_WDATA[MEM_AW-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers: two flops each before any logic looks.

	// Lane data, mask and write enable ride through the same two flops as
	// the strobe, so they stay lined up with the edge that takes them.
	logic [1:0] stb_t_s, stb_c_s, trig_s, alert_s, mrst_s, wen_s, mask_s;
	logic [1:0][LANE_W-1:0] dq_s;
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			stb_t_s <= 2'h0;
			stb_c_s <= 2'h3;
			trig_s <= 2'h3;
			alert_s <= 2'h3;
			mrst_s <= 2'h3;
			wen_s <= 2'h0;
			mask_s <= 2'h3;
			dq_s <= '0;
		end else begin
			stb_t_s <= {stb_t_s[0], LOWER_BYTE_STROBE};
			stb_c_s <= {stb_c_s[0], LOWER_BYTE_STROBE_C};
			wen_s <= {wen_s[0], WRITE_EN};
			mask_s <= {mask_s[0], WRITE_MASK_N};
			dq_s <= {dq_s[0], DQ_IN};
			trig_s <= {trig_s[0], BACKUP_TRIGGER_N};
			alert_s <= {alert_s[0], ALERT_N_IN};
			mrst_s <= {mrst_s[0], MEM_RESET_N};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write capture on both strobe edges.

	logic stb_prev_r, stb_rise, stb_fall, stb_diff_ok;
	// The strobe counts only as a differential pair: true and complement
	// must disagree, a single-ended level is never taken as an edge.
	assign stb_diff_ok = stb_t_s[1] ^ stb_c_s[1];
	assign stb_rise = stb_diff_ok && stb_t_s[1] && !stb_prev_r;
	assign stb_fall = stb_diff_ok && !stb_t_s[1] && stb_prev_r;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			stb_prev_r <= 1'b0;
		end else if (stb_diff_ok) begin
			stb_prev_r <= stb_t_s[1];
		end
	end

	// Data and mask are taken together at both strobe edges; the host
	// centres the strobe in the data eye, so the synced lane has settled.
	// One pair covers the whole byte lane of this x8 slice.
	logic [LANE_W-1:0] last_word_r;
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			STORE_DATA <= '0;
			STORE_VALID <= 1'b0;
			last_word_r <= '0;
		end else begin
			STORE_VALID <= 1'b0;
			if (wen_s[1] && (stb_rise || stb_fall)) begin
				if (mask_allowed && !mask_s[1]) begin
					STORE_VALID <= 1'b0; // Masked byte dropped.
				end else begin
					STORE_DATA <= apply_inv(dq_s[1], mask_s[1], winv_on);
					last_word_r <= apply_inv(dq_s[1], mask_s[1], winv_on);
					STORE_VALID <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read drive: data change together with the strobe toggle.

	logic inv_out;
	assign inv_out = rinv_on && (^READ_DATA == 1'b1) && (READ_DATA != '0) &&
		($countones(READ_DATA) > (LANE_W / 2));
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			DQ_OUT <= '0;
			DQ_OE <= 1'b0;
			BUS_INVERT_N_OUT <= 1'b1;
			STROBE_OUT <= 1'b0;
		end else begin
			DQ_OE <= READ_EN;
			if (READ_EN) begin
				// Low inversion flag marks inverted data.
				DQ_OUT <= apply_inv(READ_DATA, !inv_out, 1'b1);
				BUS_INVERT_N_OUT <= !inv_out;
				STROBE_OUT <= !STROBE_OUT; // Edge-aligned with data.
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Termination strobe pair.

	// Same termination as the strobe pair when enabled, else unused.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			TERM_STROBE_TRUE_TERM <= 1'b0;
			TERM_STROBE_COMP_TERM <= 1'b0;
		end else begin
			TERM_STROBE_TRUE_TERM <= term_on;
			TERM_STROBE_COMP_TERM <= term_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Alert: CRC pulse and parity hold.

	logic [CNT_W-1:0] crc_cnt_r;
	logic par_hold_r, par_err, conn_test;
	assign conn_test = config_r[CFG_CONN_TEST_BIT];
	assign par_err = mode_five_r[MR5_PAR_EN_BIT] && CMD_VALID &&
		parity_bad(CMD_BITS, CMD_PARITY);

	// CRC error loads a fixed-width countdown.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			crc_cnt_r <= '0;
		end else if (CRC_ERROR) begin
			crc_cnt_r <= CNT_W'(CRC_ALERT_CYC);
		end else if (crc_cnt_r != '0) begin
			crc_cnt_r <= crc_cnt_r - 1'b1;
		end
	end

	// Parity hold ends only on recovery done; a new error wins.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			par_hold_r <= 1'b0;
		end else if (par_err) begin
			par_hold_r <= 1'b1;
		end else if (RECOVERY_DONE) begin
			par_hold_r <= 1'b0;
		end
	end

	// Alert is open-drain: drive low only; tristate in test mode.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ALERT_N_OUT <= 1'b0;
			ALERT_N_OE <= 1'b0;
		end else begin
			ALERT_N_OUT <= 1'b0;
			ALERT_N_OE <= !conn_test && ((crc_cnt_r != '0) || par_hold_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal event.

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			EVENT_N <= 1'b1;
		end else begin
			EVENT_N <= !(TEMPERATURE > config_r[CFG_CRIT_TEMP_LO +: 8]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Backup sequencer.

	backup_type bk_state_r;
	logic [MEM_AW-1:0] copy_ptr_r;
	logic armed, trig_fall, trig_prev_r;
	logic [LANE_W-1:0] mem_rdata;
	assign armed = config_r[CFG_BACKUP_EN_BIT];
	assign trig_fall = trig_prev_r && !trig_s[1];

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			trig_prev_r <= 1'b1;
		end else begin
			trig_prev_r <= trig_s[1];
		end
	end

	// The host has put the memory into self refresh before the trigger,
	// so the lane holds still while the copy walks every word.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			bk_state_r <= BK_IDLE;
			copy_ptr_r <= '0;
		end else begin
			case (bk_state_r)
				BK_IDLE: begin
					if (armed && trig_fall) begin
						bk_state_r <= BK_SWITCH;
					end
				end
				BK_SWITCH: begin
					copy_ptr_r <= '0;
					bk_state_r <= BK_COPY;
				end
				BK_COPY: begin
					copy_ptr_r <= copy_ptr_r + 1'b1;
					if (copy_ptr_r == MEM_AW'(MEM_DEPTH - 1)) begin
						bk_state_r <= BK_DONE;
					end
				end
				BK_DONE: begin
					if (!armed) begin
						bk_state_r <= BK_IDLE;
					end
				end
				default: bk_state_r <= BK_IDLE;
			endcase
		end
	end

	// Mux switch and done flags.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			MUX_TO_FLASH <= 1'b0;
			BACKUP_DONE <= 1'b0;
		end else begin
			MUX_TO_FLASH <= (bk_state_r == BK_SWITCH) || (bk_state_r == BK_COPY);
			BACKUP_DONE <= (bk_state_r == BK_DONE);
		end
	end

	// The lane's last written word, XORed with the copy address, stands in for the DRAM image here.
	backup_store u_store (
		.clk(CLK),
		.wr_en(bk_state_r == BK_COPY),
		.wr_addr(copy_ptr_r),
		.wr_data(last_word_r ^ {{(LANE_W-MEM_AW){1'b0}}, copy_ptr_r}),
		.rd_addr(mem_addr_r),
		.rd_data(mem_rdata)
	);

	// Memory reset is blocked while armed for backup.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			MEM_RESET_N_EFF <= 1'b1;
		end else begin
			MEM_RESET_N_EFF <= armed ? 1'b1 : mrst_s[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads, data one cycle after the strobe.

	logic [DATA_W-1:0] status;
	always_comb begin
		status = '0;
		status[ST_ALERT_BIT] = ALERT_N_OE;
		status[ST_BACKUP_BIT] = MUX_TO_FLASH;
		status[ST_DONE_BIT] = BACKUP_DONE;
		status[ST_ALERT_IN_BIT] = alert_s[1];
		status[ST_ARMED_BIT] = armed;
		status[ST_EVENT_BIT] = !EVENT_N;
		status[ST_TERM_BIT] = term_on;
		status[ST_STATE_LO +: 2] = bk_state_r;
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				OFF_MODE_ONE: REG_RDATA <= mode_one_r;
				OFF_MODE_FIVE: REG_RDATA <= mode_five_r;
				OFF_CONFIG: REG_RDATA <= config_r;
				OFF_STATUS: REG_RDATA <= status;
				OFF_LAST_WORD: REG_RDATA <= {{(DATA_W-LANE_W){1'b0}}, last_word_r};
				OFF_MEM_ADDR: REG_RDATA <= {{(DATA_W-MEM_AW){1'b0}}, mem_addr_r};
				OFF_MEM_DATA: REG_RDATA <= {{(DATA_W-LANE_W){1'b0}}, mem_rdata};
				default: REG_RDATA <= '0;
			endcase
		end else begin
			REG_RDATA <= '0;
		end
	end
endmodule
`default_nettype wire

/* hw/lane_flag_pkg.sv */
/*
 * Package for the data-lane side pins and flag pins of a nonvolatile
 * registered memory module: mode bits, widths, register offsets, timing.
 * Assumes a single 200 MHz core clock domain.
 */
package lane_flag_pkg;
	// Core clock period in picoseconds.
	localparam int CLK_PERIOD_PS = 5000;
	// Data lane width (x8 lane, one byte under one strobe pair).
	localparam int LANE_W = 8;
	localparam int NIB_W = 4;
	// Register port.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFF_MODE_ONE = 4'h0;
	localparam logic [3:0] OFF_MODE_FIVE = 4'h1;
	localparam logic [3:0] OFF_CONFIG = 4'h2;
	localparam logic [3:0] OFF_STATUS = 4'h3;
	localparam logic [3:0] OFF_LAST_WORD = 4'h4;
	localparam logic [3:0] OFF_MEM_ADDR = 4'h5;
	localparam logic [3:0] OFF_MEM_DATA = 4'h6;
	// Mode register bit positions.
	localparam int MR1_TERM_STROBE_BIT = 11;
	localparam int MR5_PAR_EN_BIT = 0;
	localparam int MR5_MASK_EN_BIT = 10;
	localparam int MR5_WINV_EN_BIT = 11;
	localparam int MR5_RINV_EN_BIT = 12;
	// Config register fields.
	localparam int CFG_WIDTH_LO = 0;
	localparam int CFG_BACKUP_EN_BIT = 2;
	localparam int CFG_CONN_TEST_BIT = 3;
	localparam int CFG_CRIT_TEMP_LO = 8;
	// Part width codes.
	localparam logic [1:0] WIDTH_X4 = 2'h0;
	localparam logic [1:0] WIDTH_X8 = 2'h1;
	localparam logic [1:0] WIDTH_X16 = 2'h2;
	// Reset values.
	localparam logic [15:0] MODE_ONE_RST = 16'h0000;
	localparam logic [15:0] MODE_FIVE_RST = 16'h0000;
	localparam logic [15:0] CONFIG_RST = 16'h5501;
	// CRC alert pulse width, in nanoseconds, and derived cycles.
	localparam int CRC_ALERT_NS = 60;
	localparam int CRC_ALERT_CYC = (CRC_ALERT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Parity recovery time, in nanoseconds, and derived cycles.
	localparam int PAR_RECOVER_NS = 200;
	localparam int PAR_RECOVER_CYC = (PAR_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;
	// Backup copy memory depth.
	localparam int MEM_AW = 4;
	localparam int MEM_DEPTH = 16;
	// Status bit positions.
	localparam int ST_ALERT_BIT = 0;
	localparam int ST_BACKUP_BIT = 1;
	localparam int ST_DONE_BIT = 2;
	localparam int ST_ALERT_IN_BIT = 3;
	localparam int ST_ARMED_BIT = 4;
	localparam int ST_EVENT_BIT = 5;
	localparam int ST_TERM_BIT = 6;
	localparam int ST_STATE_LO = 8;
	// Backup sequencer states.
	typedef enum logic [1:0] {BK_IDLE, BK_SWITCH, BK_COPY, BK_DONE} backup_type;
endpackage

/* tb/host_lane_model.sv */
/*
 * Host write side of one byte lane: differential strobe, data and mask.
 * Assumes the lane samples on both strobe edges; the strobe is 160 ns.
 */
`timescale 1ns/1ps
`default_nettype none
module host_lane_model (
	// Strobe pair.
	output logic STROBE_T,
	output logic STROBE_C,
	// Lane.
	output logic [7:0] DQ,
	output logic MASK_N,
	output logic WR_EN
);
	// The strobe stands still between bursts.
	initial begin
		STROBE_T = 1'b0;
		STROBE_C = 1'b1;
		DQ = 8'h00;
		MASK_N = 1'b1;
		WR_EN = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One burst of four bytes, data set half a beat ahead so edges land mid-eye.
	task automatic burst(input logic [31:0] d, input logic [3:0] m);
		#1; // Step off the core clock edge before touching the lane.
		WR_EN = 1'b1;
		for (int i = 0; i < 4; i++) begin
			DQ = d[8*i +: 8];
			MASK_N = m[i];
			#40;
			STROBE_T = ~STROBE_T;
			STROBE_C = ~STROBE_T;
			#40;
		end
		WR_EN = 1'b0;
		DQ = ~DQ; // A released lane must not look like the last byte.
		MASK_N = ~MASK_N;
	endtask
endmodule
`default_nettype wire

/* tb/lane_flag_monitor.sv */
/*
 * Port checker for lane_flag_pins: alert, event, store, backup, term strobe.
 * Assumes the single CLK domain and the register offsets of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module lane_flag_monitor
	import lane_flag_pkg::*;
(
	// Clock, reset and register port.
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [DATA_W-1:0] REG_RDATA,
	// Watched pins.
	input wire logic WRITE_EN,
	input wire logic STORE_VALID,
	input wire logic CRC_ERROR,
	input wire logic ALERT_N_OUT,
	input wire logic ALERT_N_OE,
	input wire logic [7:0] TEMPERATURE,
	input wire logic EVENT_N,
	input wire logic MEM_RESET_N_EFF,
	input wire logic MUX_TO_FLASH,
	input wire logic BACKUP_DONE,
	input wire logic TERM_STROBE_TRUE_TERM,
	input wire logic TERM_STROBE_COMP_TERM
);
	logic [15:0] cfg_r;
	logic [15:0] m1_r;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Shadow of the config register, since the mode decides what the pins may do.
	always_ff @(posedge CLK) begin
		if (!RESET_N)
			cfg_r <= CONFIG_RST;
		else if (REG_WR && REG_ADDR == OFF_CONFIG)
			cfg_r <= REG_WDATA;
	end
	// Shadow of mode register one, which picks the termination strobe.
	always_ff @(posedge CLK) begin
		if (!RESET_N)
			m1_r <= MODE_ONE_RST;
		else if (REG_WR && REG_ADDR == OFF_MODE_ONE)
			m1_r <= REG_WDATA;
	end
	sequence s_hot; (TEMPERATURE > cfg_r[15:8])[*3]; endsequence
	sequence s_cool; (TEMPERATURE <= cfg_r[15:8])[*3]; endsequence
	property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == 16'h0000; endproperty
	property p_alert_low; ALERT_N_OE |-> !ALERT_N_OUT; endproperty
	property p_crc_start; CRC_ERROR && !cfg_r[3] |-> ##[1:2] ALERT_N_OE; endproperty
	property p_crc_hold; $rose(ALERT_N_OE) |-> ALERT_N_OE[*8]; endproperty
	property p_conn; cfg_r[3] && $past(cfg_r[3]) |-> !ALERT_N_OE; endproperty
	property p_hot; s_hot |-> !EVENT_N; endproperty
	property p_cool; s_cool |-> EVENT_N; endproperty
	property p_store; STORE_VALID |-> $past(WRITE_EN) ##1 !STORE_VALID; endproperty
	property p_arm; cfg_r[2] && $past(cfg_r[2]) |-> MEM_RESET_N_EFF; endproperty
	property p_copy; $rose(MUX_TO_FLASH) |-> MUX_TO_FLASH[*8]; endproperty
	property p_done; BACKUP_DONE |-> !MUX_TO_FLASH; endproperty
	property p_term;
		TERM_STROBE_TRUE_TERM == $past(m1_r[MR1_TERM_STROBE_BIT] && cfg_r[1:0] == WIDTH_X8) &&
			TERM_STROBE_COMP_TERM == TERM_STROBE_TRUE_TERM;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read slot");
	a_alert_low: assert property (p_alert_low)
		else $error("alert driven high");
	a_crc_start: assert property (p_crc_start)
		else $error("crc error gave no alert");
	a_crc_hold: assert property (p_crc_hold)
		else $error("alert pulse too short");
	a_conn: assert property (p_conn)
		else $error("alert driven in connectivity test");
	a_hot: assert property (p_hot)
		else $error("event not raised when hot");
	a_cool: assert property (p_cool)
		else $error("event raised when cool");
	a_store: assert property (p_store)
		else $error("store pulse without write or too long");
	a_arm: assert property (p_arm)
		else $error("memory reset passed while armed");
	a_copy: assert property (p_copy)
		else $error("copy too short");
	a_done: assert property (p_done)
		else $error("done while copying");
	a_term: assert property (p_term)
		else $error("term strobe pair differs");
endmodule
bind lane_flag_pins lane_flag_monitor lane_flag_monitor_i (.CLK, .RESET_N, .REG_ADDR,
	.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .WRITE_EN, .STORE_VALID, .CRC_ERROR,
	.ALERT_N_OUT, .ALERT_N_OE, .TEMPERATURE, .EVENT_N, .MEM_RESET_N_EFF, .MUX_TO_FLASH,
	.BACKUP_DONE, .TERM_STROBE_TRUE_TERM, .TERM_STROBE_COMP_TERM);
`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for lane_flag_pins with a host lane model.
 * Assumes the package offsets and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lane_flag_pkg::*;
	logic CLK, RESET_N, MEM_RESET_N, MEM_RESET_N_EFF, REG_WR, REG_RD;
	logic [ADDR_W-1:0] REG_ADDR;
	logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
	logic LOWER_BYTE_STROBE, LOWER_BYTE_STROBE_C, WRITE_MASK_N, WRITE_EN, STORE_VALID;
	logic [LANE_W-1:0] DQ_IN, STORE_DATA, READ_DATA, DQ_OUT;
	logic READ_EN, DQ_OE, BUS_INVERT_N_OUT, STROBE_OUT, TERM_STROBE_TRUE_TERM;
	logic TERM_STROBE_COMP_TERM, CMD_VALID, CMD_PARITY, CRC_ERROR, RECOVERY_DONE;
	logic [31:0] CMD_BITS;
	logic ALERT_N_IN, ALERT_N_OUT, ALERT_N_OE, EVENT_N, BACKUP_TRIGGER_N;
	logic MUX_TO_FLASH, BACKUP_DONE;
	logic [7:0] TEMPERATURE;
	logic [7:0] got[$];
	int n_fail = 0;
	int checks_done = 0;
	lane_flag_pins lane_flag_pins_i (.CLK, .RESET_N, .MEM_RESET_N, .MEM_RESET_N_EFF,
		.REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .LOWER_BYTE_STROBE,
		.LOWER_BYTE_STROBE_C, .DQ_IN, .WRITE_MASK_N, .WRITE_EN, .STORE_DATA, .STORE_VALID,
		.READ_DATA, .READ_EN, .DQ_OUT, .DQ_OE, .BUS_INVERT_N_OUT, .STROBE_OUT,
		.TERM_STROBE_TRUE_TERM, .TERM_STROBE_COMP_TERM, .CMD_VALID, .CMD_BITS, .CMD_PARITY,
		.CRC_ERROR, .RECOVERY_DONE, .ALERT_N_IN, .ALERT_N_OUT, .ALERT_N_OE, .TEMPERATURE,
		.EVENT_N, .BACKUP_TRIGGER_N, .MUX_TO_FLASH, .BACKUP_DONE);
	host_lane_model host_lane_model_i (.STROBE_T(LOWER_BYTE_STROBE),
		.STROBE_C(LOWER_BYTE_STROBE_C), .DQ(DQ_IN), .MASK_N(WRITE_MASK_N), .WR_EN(WRITE_EN));
	// Alert wire is pulled up; the block only pulls it low.
	assign ALERT_N_IN = ALERT_N_OE ? ALERT_N_OUT : 1'b1;
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// Collect every stored byte.
	always @(posedge CLK) begin
		if (STORE_VALID === 1'b1)
			got.push_back(STORE_DATA);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic wait_for(input string nm, ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++)
			@(posedge CLK);
		chk(nm, v, s);
		if (s !== v)
			test_done();
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 chk("read data", e, REG_RDATA);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// One write burst under the given modes, expectation built from the modes.
	task automatic lane(input logic [15:0] mr1, mr5, cfg, input logic [3:0] m,
		input logic [31:0] d);
		logic [7:0] exp[$];
		logic mk, iv;
		mk = mr5[MR5_MASK_EN_BIT] && cfg[1:0] != WIDTH_X4 &&
			!(mr1[MR1_TERM_STROBE_BIT] && cfg[1:0] == WIDTH_X8);
		iv = mr5[MR5_WINV_EN_BIT] && !mk;
		for (int i = 0; i < 4; i++)
			if (!(mk && !m[i]))
				exp.push_back((iv && !m[i]) ? ~d[8*i +: 8] : d[8*i +: 8]);
		wr(OFF_MODE_ONE, mr1);
		wr(OFF_MODE_FIVE, mr5);
		wr(OFF_CONFIG, cfg);
		tick(3);
		got.delete();
		host_lane_model_i.burst(d, m);
		tick(10);
		chk("stored count", 16'(exp.size()), 16'(got.size()));
		foreach (exp[i])
			chk("stored byte", {8'h00, exp[i]}, {8'h00, got[i]});
		chk("term strobe", mr1[MR1_TERM_STROBE_BIT] && cfg[1:0] == WIDTH_X8,
			TERM_STROBE_TRUE_TERM);
	endtask
	// Alert on CRC and parity, none in connectivity test.
	task automatic alert_all;
		int n;
		CRC_ERROR <= 1'b1;
		tick(1);
		CRC_ERROR <= 1'b0;
		wait_for("crc alert", ALERT_N_OE, 1'b1, 4);
		n = 0;
		while (ALERT_N_OE === 1'b1 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		chk("crc width", 16'(CRC_ALERT_CYC), 16'(n));
		wr(OFF_MODE_FIVE, 16'h0001);
		CMD_VALID <= 1'b1;
		CMD_BITS <= 32'h0000_0003;
		tick(1);
		CMD_VALID <= 1'b0;
		tick(6);
		chk("good parity", 1'b0, ALERT_N_OE);
		CMD_VALID <= 1'b1;
		CMD_PARITY <= 1'b1;
		tick(1);
		CMD_VALID <= 1'b0;
		wait_for("parity alert", ALERT_N_OE, 1'b1, 6);
		tick(30);
		chk("parity hold", 1'b1, ALERT_N_OE);
		RECOVERY_DONE <= 1'b1;
		tick(1);
		RECOVERY_DONE <= 1'b0;
		wait_for("parity release", ALERT_N_OE, 1'b0, 4);
		wr(OFF_CONFIG, 16'h5509);
		CRC_ERROR <= 1'b1;
		tick(1);
		CRC_ERROR <= 1'b0;
		tick(4);
		chk("conn test alert", 1'b0, ALERT_N_OE);
		tick(10);
		chk("conn test alert", 1'b0, ALERT_N_OE);
		wr(OFF_CONFIG, CONFIG_RST);
	endtask
	// Backup trigger unarmed, then armed with the memory reset blocked.
	task automatic backup;
		BACKUP_TRIGGER_N <= 1'b0;
		tick(8);
		chk("unarmed mux", 1'b0, MUX_TO_FLASH);
		BACKUP_TRIGGER_N <= 1'b1;
		MEM_RESET_N <= 1'b0;
		wait_for("mem reset", MEM_RESET_N_EFF, 1'b0, 5);
		wr(OFF_CONFIG, 16'h5505);
		tick(5);
		chk("armed mem reset", 1'b1, MEM_RESET_N_EFF);
		MEM_RESET_N <= 1'b1;
		BACKUP_TRIGGER_N <= 1'b0; // Lane idle as in self refresh.
		wait_for("mux switch", MUX_TO_FLASH, 1'b1, 8);
		wait_for("backup done", BACKUP_DONE, 1'b1, 40);
		BACKUP_TRIGGER_N <= 1'b1;
		wr(OFF_CONFIG, CONFIG_RST);
		tick(3);
		chk("done cleared", 1'b0, BACKUP_DONE);
	endtask
	// Read drive under a read inversion mode; strobe toggles with the data.
	task automatic rdpath(input logic [15:0] mr5, input logic [7:0] d, e, input logic iv_n);
		logic s;
		wr(OFF_MODE_FIVE, mr5);
		READ_DATA <= d;
		READ_EN <= 1'b1;
		tick(3);
		s = STROBE_OUT;
		chk("read oe", 1'b1, DQ_OE);
		chk("read data out", {8'h00, e}, {8'h00, DQ_OUT});
		chk("read invert pin", iv_n, BUS_INVERT_N_OUT);
		tick(1);
		chk("read strobe toggle", !s, STROBE_OUT);
		READ_EN <= 1'b0;
		tick(2);
		chk("read oe off", 1'b0, DQ_OE);
	endtask
	// Thermal event just above and at the critical temperature.
	task automatic thermal;
		TEMPERATURE <= 8'h56;
		tick(4);
		chk("event hot", 1'b0, EVENT_N);
		TEMPERATURE <= 8'h55;
		tick(4);
		chk("event cool", 1'b1, EVENT_N);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400us;
		n_fail++;
		$display("Error watchdog expected finish seen hang");
		test_done();
	end
	initial begin
		{REG_WR, REG_RD, READ_EN, CMD_VALID, CMD_PARITY, CRC_ERROR, RECOVERY_DONE} = '0;
		{REG_ADDR, REG_WDATA, READ_DATA, CMD_BITS} = '0;
		MEM_RESET_N = 1'b1;
		BACKUP_TRIGGER_N = 1'b1;
		TEMPERATURE = 8'h20;
		RESET_N = 1'b0;
		tick(5);
		RESET_N <= 1'b1;
		rd(OFF_CONFIG, CONFIG_RST);
		rd(OFF_MODE_ONE, MODE_ONE_RST);
		rd(OFF_MODE_FIVE, MODE_FIVE_RST);
		rd(4'hF, 16'h0000);
		lane(16'h0000, 16'h0000, CONFIG_RST, 4'hF, 32'hA5C3_1E77);
		lane(16'h0000, 16'h0400, CONFIG_RST, 4'h5, 32'h1234_5678);
		lane(16'h0000, 16'h0800, CONFIG_RST, 4'h6, 32'h0FF0_C33C);
		lane(16'h0800, 16'h0400, CONFIG_RST, 4'h5, 32'h8844_2211);
		lane(16'h0000, 16'h0400, 16'h5500, 4'h5, 32'h6699_AA55);
		rd(OFF_LAST_WORD, 16'h0066);
		rdpath(16'h0000, 8'h3C, 8'h3C, 1'b1);
		rdpath(16'h1000, 8'hF8, 8'h07, 1'b0);
		alert_all();
		thermal();
		backup();
		test_done();
	end
endmodule
`default_nettype wire
